// *** rtl/gps_pkg.sv ***
// shared constants for the pin-select gpio port
// assumes one 50 MHz clock and an axi4-lite master outside
package gps_pkg;

  // ==========================================================
  // sizes
  localparam int NPIN = 16;
  localparam int NRMP = 46;
  localparam int NEXT = NRMP - NPIN;
  localparam int NPER = 4;
  localparam int SELW = 4;
  localparam int RINW = 6;
  localparam logic [15:0] IMPL_MASK = 16'h7fff;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] A_DIR = 8'h00;
  localparam logic [7:0] A_LAT = 8'h04;
  localparam logic [7:0] A_PIN = 8'h08;
  localparam logic [7:0] A_ODC = 8'h0c;
  localparam logic [7:0] A_APC = 8'h10;
  localparam logic [7:0] A_CNE = 8'h14;
  localparam logic [7:0] A_WPU = 8'h18;
  localparam logic [7:0] A_WPD = 8'h1c;
  localparam logic [7:0] A_CNS = 8'h20;
  localparam logic [7:0] A_RIN = 8'h24;
  localparam logic [7:0] A_RO0 = 8'h28;
  localparam logic [7:0] A_RO1 = 8'h2c;

  // ==========================================================
  // reset values and selector limits
  localparam logic [15:0] DIR_RST = IMPL_MASK;
  localparam logic [5:0] RIN_RST = 6'h3f;
  localparam logic [5:0] RIN_MAX = 6'h2d;
  localparam logic [3:0] SEL_NULL = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h4;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ==========================================================
  // bus channel states
  typedef enum logic {W_IDLE = 1'b0, W_RESP = 1'b1} gps_wst_t;
  typedef enum logic {R_IDLE = 1'b0, R_DATA = 1'b1} gps_rst_t;

  // byte strobes to a bit mask
  function automatic logic [31:0] gps_smask(input logic [3:0] s);
    gps_smask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : gps_smask

endpackage : gps_pkg

// *** rtl/gps_if.sv ***
// signals between the register block and the pin ownership mux
// assumes both ends share one clock
`timescale 1ns/1ns
interface gps_if;
  import gps_pkg::*;
  logic [NPIN-1:0] dir, lat, odc, apc;
  logic [NPIN-1:0][SELW-1:0] rsel;
  logic [NPIN-1:0] fen, foe, fout;
  logic [NPER-1:0] pout, poe;
  logic [NPIN-1:0] dout, oe_n, pdrv;
  modport mux (input dir, lat, odc, apc, rsel, fen, foe, fout,
    pout, poe, output dout, oe_n, pdrv);
  modport ctl (output dir, lat, odc, apc, rsel, fen, foe, fout,
    pout, poe, input dout, oe_n, pdrv);
endinterface : gps_if

// *** rtl/gps_mux.sv ***
// per-pin ownership of output data and output enable
// assumes config comes from registers on the same clock
`timescale 1ns/1ns
module gps_mux
  import gps_pkg::*;
(
  gps_if.mux pm // config in, pad drive out
);

  logic [2**SELW-1:0] pv, ev;

  // slot 0 is the null function
  assign pv = (2**SELW)'({pm.pout, 1'b0});
  assign ev = (2**SELW)'({pm.poe, 1'b0});

  // ==========================================================
  // pin cells
  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_pin
      logic rem, fix, d0, e0;
      // analog use blocks every remapped function
      assign rem = (pm.rsel[i] != SEL_NULL) &&
        (pm.rsel[i] <= SEL_MAX) && !pm.apc[i]; // R16 R17
      assign fix = pm.fen[i] && pm.foe[i] && !pm.apc[i] && !rem; // R1
      always_comb begin
        if (rem) begin
          d0 = pv[pm.rsel[i]]; // R16
          e0 = ev[pm.rsel[i]];
        end else if (fix) begin
          d0 = pm.fout[i]; // R1
          e0 = 1'b1;
        end else begin
          d0 = pm.lat[i]; // R2
          e0 = !pm.dir[i]; // R4
        end
      end
      // open drain only ever pulls low
      assign pm.dout[i] = pm.odc[i] ? 1'b0 : d0; // R8
      assign pm.oe_n[i] = !(IMPL_MASK[i] && e0 &&
        !(pm.odc[i] && d0)); // R8 R7
      assign pm.pdrv[i] = IMPL_MASK[i] && !rem && !fix &&
        !pm.dir[i];
    end
  endgenerate

endmodule : gps_mux

// *** rtl/gps_top.sv ***
// gpio port with pin select, registers over axi4-lite
// assumes pins and remap pins are asynchronous, peripherals local
//
// How it works
// R1: an enabled peripheral that drives a pin owns it; port driver off
// R2: an enabled peripheral not driving leaves the pin to the port
// R3: port output never loops into a peripheral input on that pin
// R4: direction bit one means input, zero means output
// R5: after reset every implemented pin is an input
// R6: latch reads latch; pin register reads pins; both writes hit latch
// R7: unimplemented bits of latch, direction and pins read zero
// R8: open drain bit per pin: drive low only, release for high
// R9: analog pins read zero in the pin register
// R10: analog pin with direction cleared still gets the port level
// R11: software waits one cycle between a port write and its read
// R12: a change on an enabled pin raises the change request
// R13: each input has its own change notice enable bit
// R14: each pin has separate weak pull-up and pull-down enables
// R15: software drops the pull-up on digital outputs
// R16: an active remapped function beats port and fixed peripherals
// R17: analog use always beats remapped functions
// R18: remapped functions start unconnected until software maps them
// R19: 46 remap pins; 0 to 15 both ways, 16 to 45 input only
// R20: input and output routing live in separate registers
// R21: fixed peripherals sit on their own pin when active
// R22: no routing for bus, change notice, alarm or analog functions
// R23: flag sets when enabled synced level differs from last sample
`timescale 1ns/1ns
module gps_top
  import gps_pkg::*;
(
  input wire logic CLK, // 50 MHz
  input wire logic RSTN, // async reset, low
  input wire logic [7:0] AWADDR, // write address
  input wire logic AWVALID, // write address valid
  output logic AWREADY, // write address taken
  input wire logic [31:0] WDATA, // write data
  input wire logic [3:0] WSTRB, // byte strobes
  input wire logic WVALID, // write data valid
  output logic WREADY, // write data taken
  output logic [1:0] BRESP, // write response
  output logic BVALID, // response valid
  input wire logic BREADY, // response taken
  input wire logic [7:0] ARADDR, // read address
  input wire logic ARVALID, // read address valid
  output logic ARREADY, // read address taken
  output logic [31:0] RDATA, // read data
  output logic [1:0] RRESP, // read response
  output logic RVALID, // read data valid
  input wire logic RREADY, // read data taken
  input wire logic [NPIN-1:0] PIN_IN, // pad levels
  output logic [NPIN-1:0] PIN_OUT, // pad data
  output logic [NPIN-1:0] PIN_OE_N, // pad enable, low drives
  output logic [NPIN-1:0] PU_EN, // weak pull-up on
  output logic [NPIN-1:0] PD_EN, // weak pull-down on
  input wire logic [NEXT-1:0] RP_EXT, // remap pins 16 to 45
  input wire logic [NPIN-1:0] FIX_EN, // fixed peripheral enabled
  input wire logic [NPIN-1:0] FIX_OE, // fixed peripheral drives
  input wire logic [NPIN-1:0] FIX_OUT, // fixed peripheral data
  output logic [NPIN-1:0] FIX_IN, // fixed peripheral input
  input wire logic [NPER-1:0] PER_OUT, // remappable outputs
  input wire logic [NPER-1:0] PER_OE, // remappable drives
  output logic [1:0] RMP_IN, // remappable inputs
  output logic CN_REQ // change notice request
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] lat;
    logic [NPIN-1:0] odc;
    logic [NPIN-1:0] apc;
    logic [NPIN-1:0] cne;
    logic [NPIN-1:0] wpu;
    logic [NPIN-1:0] wpd;
    logic cnf;
    logic [1:0][RINW-1:0] rin;
    logic [NPIN-1:0][SELW-1:0] rout;
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] prev;
    logic [NEXT-1:0] e1;
    logic [NEXT-1:0] e2;
    gps_wst_t ws;
    gps_rst_t rs;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } gps_st_t;

  localparam gps_st_t ST_RST = '{dir: DIR_RST,
    rin: {RIN_RST, RIN_RST}, ws: W_IDLE, rs: R_IDLE,
    default: '0};

  gps_st_t q, d;
  logic [31:0] wm;
  logic [NRMP-1:0] src;
  logic cn_hit;
  logic cn_clr;
  gps_if pif ();

  // ==========================================================
  // helpers
  function automatic logic [15:0] mrg16(input logic [15:0] o,
    input logic [31:0] w, input logic [31:0] m);
    mrg16 = (o & ~m[15:0]) | (w[15:0] & m[15:0]);
  endfunction : mrg16

  function automatic logic [31:0] mrg32(input logic [31:0] o,
    input logic [31:0] w, input logic [31:0] m);
    mrg32 = (o & ~m) | (w & m);
  endfunction : mrg32

  function automatic logic known(input logic [7:0] a);
    known = (a[1:0] == 2'h0) && (a <= A_RO1);
  endfunction : known

  // ==========================================================
  // pin ownership
  assign pif.dir = q.dir;
  assign pif.lat = q.lat;
  assign pif.odc = q.odc;
  assign pif.apc = q.apc;
  assign pif.rsel = q.rout; // R18 R20
  assign pif.fen = FIX_EN;
  assign pif.foe = FIX_OE;
  assign pif.fout = FIX_OUT;
  assign pif.pout = PER_OUT;
  assign pif.poe = PER_OE;

  gps_mux u_mux (
    .pm (pif.mux)
  );

  assign PIN_OUT = pif.dout;
  assign PIN_OE_N = pif.oe_n;
  // pulls are plain register bits; software keeps pull-up off outputs
  assign PU_EN = q.wpu & IMPL_MASK; // R14
  assign PD_EN = q.wpd & IMPL_MASK; // R14

  // ==========================================================
  // peripheral inputs, blind to our own port drive
  assign FIX_IN = q.s2 & ~q.apc & ~pif.pdrv; // R3 R21
  assign src = {q.e2, FIX_IN}; // R19
  // only digital remap pins; bus, notice and analog are not routed
  generate
    for (genvar j = 0; j < 2; j++) begin : g_rin
      assign RMP_IN[j] = (q.rin[j] <= RIN_MAX) ?
        src[q.rin[j]] : 1'b0; // R19 R18 R22
    end
  endgenerate

  // ==========================================================
  // change notice on synced levels only; a stopped clock sees nothing
  assign cn_hit = |(q.cne & IMPL_MASK & (q.s2 ^ q.prev)); // R12 R13 R23
  assign CN_REQ = q.cnf;
  // software clear: a one in bit 0 of the flag register
  assign cn_clr = AWREADY && (AWADDR == A_CNS) && WDATA[0] && wm[0];

  // ==========================================================
  // bus handshakes
  assign wm = gps_smask(WSTRB);
  assign AWREADY = (q.ws == W_IDLE) && AWVALID && WVALID;
  assign WREADY = AWREADY;
  assign BVALID = (q.ws == W_RESP);
  assign BRESP = q.bresp;
  assign ARREADY = (q.rs == R_IDLE);
  assign RVALID = (q.rs == R_DATA);
  assign RRESP = q.rresp;
  assign RDATA = q.rdata;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.s1 = PIN_IN;
    d.s2 = q.s1;
    d.e1 = RP_EXT;
    d.e2 = q.e1;
    d.prev = q.s2;
    // a clear in the same cycle as a change loses
    if (cn_clr) begin
      d.cnf = 1'b0;
    end
    if (cn_hit) begin
      d.cnf = 1'b1; // R23 R12
    end
    // write channel: address and data taken together
    unique case (q.ws)
      W_IDLE: begin
        if (AWVALID && WVALID) begin
          d.ws = W_RESP;
          d.bresp = known(AWADDR) ? RESP_OK : RESP_ERR;
          case (AWADDR)
            A_DIR: d.dir = mrg16(q.dir, WDATA, wm) & IMPL_MASK; // R4 R7
            A_LAT: d.lat = mrg16(q.lat, WDATA, wm) & IMPL_MASK; // R6 R7
            A_PIN: d.lat = mrg16(q.lat, WDATA, wm) & IMPL_MASK; // R6
            A_ODC: d.odc = mrg16(q.odc, WDATA, wm) & IMPL_MASK; // R8
            A_APC: d.apc = mrg16(q.apc, WDATA, wm) & IMPL_MASK; // R10
            A_CNE: d.cne = mrg16(q.cne, WDATA, wm) & IMPL_MASK; // R13
            A_WPU: d.wpu = mrg16(q.wpu, WDATA, wm) & IMPL_MASK; // R14
            A_WPD: d.wpd = mrg16(q.wpd, WDATA, wm) & IMPL_MASK; // R14
            A_RIN: d.rin = (2*RINW)'(mrg32(32'(q.rin), WDATA, wm)); // R20
            A_RO0: d.rout[7:0] = mrg32(q.rout[7:0], WDATA, wm); // R20
            A_RO1: d.rout[15:8] = mrg32(q.rout[15:8], WDATA, wm);
            default: ;
          endcase
        end
      end
      W_RESP: begin
        if (BREADY) begin
          d.ws = W_IDLE;
        end
      end
    endcase
    // read channel: data registered one cycle after the address
    unique case (q.rs)
      R_IDLE: begin
        if (ARVALID) begin
          d.rs = R_DATA;
          d.rresp = known(ARADDR) ? RESP_OK : RESP_ERR;
          case (ARADDR)
            A_DIR: d.rdata = 32'(q.dir); // R5
            A_LAT: d.rdata = 32'(q.lat); // R6
            A_PIN: d.rdata = 32'(q.s2 & ~q.apc & IMPL_MASK); // R6 R9 R7
            A_ODC: d.rdata = 32'(q.odc);
            A_APC: d.rdata = 32'(q.apc);
            A_CNE: d.rdata = 32'(q.cne);
            A_WPU: d.rdata = 32'(q.wpu);
            A_WPD: d.rdata = 32'(q.wpd);
            A_CNS: d.rdata = 32'(q.cnf);
            A_RIN: d.rdata = 32'(q.rin);
            A_RO0: d.rdata = q.rout[7:0];
            A_RO1: d.rdata = q.rout[15:8];
            default: d.rdata = 32'h0;
          endcase
        end
      end
      R_DATA: begin
        if (RREADY) begin
          d.rs = R_IDLE;
        end
      end
    endcase
  end

  // state register; reset leaves all implemented pins as inputs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= ST_RST; // R5 R18
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  chk_unimpl_zero: assert property ( // R7
    ((q.dir | q.lat) & ~IMPL_MASK) == 16'h0)
    else $error("unimplemented bit set");

  chk_remap_wins: assert property ( // R16
    (q.rout[0] == 4'h1) && !q.apc[0] |->
    (PIN_OUT[0] == (PER_OUT[0] & !q.odc[0])))
    else $error("remap did not own pin 0");

  chk_analog_wins: assert property ( // R17
    q.apc[0] && !FIX_OE[0] |->
    (PIN_OE_N[0] == (q.dir[0] || (q.odc[0] && q.lat[0]))))
    else $error("analog pin not under port control");

  // pin cells are copies; watch pin 2, where a fixed peripheral sits
  chk_fixed_owns: assert property ( // R1
    FIX_EN[2] && FIX_OE[2] && !q.apc[2] && q.rout[2] == 4'h0
    && !q.odc[2] |-> !PIN_OE_N[2] && PIN_OUT[2] == FIX_OUT[2])
    else $error("fixed peripheral lost pin 2");

  chk_port_drives: assert property ( // R2
    FIX_EN[2] && !FIX_OE[2] && q.rout[2] == 4'h0 && !q.dir[2]
    && !q.odc[2] |-> !PIN_OE_N[2] && PIN_OUT[2] == q.lat[2])
    else $error("port could not drive pin 2");

  chk_no_loop: assert property ( // R3
    !PIN_OE_N[0] && q.rout[0] == 4'h0 && !FIX_OE[0] |->
    !FIX_IN[0])
    else $error("port output looped into peripheral");

  chk_od_low: assert property ( // R8
    q.odc[1] |-> PIN_OE_N[1] || !PIN_OUT[1])
    else $error("open drain drove high");

  chk_cn_sets: assert property ( // R23 R12
    cn_hit |=> CN_REQ)
    else $error("change flag missed");

  chk_cn_hold: assert property ( // R23
    CN_REQ && !cn_clr |=> CN_REQ)
    else $error("change flag dropped without a clear");

  chk_pin_analog: assert property ( // R9
    ARVALID && ARREADY && ARADDR == A_PIN |=>
    RVALID && ((RDATA[15:0] & $past(q.apc)) == 16'h0))
    else $error("analog pin read nonzero");

  chk_latch_wr: assert property ( // R6
    AWREADY && AWADDR == A_PIN && WSTRB == 4'hf |=>
    q.lat == ($past(WDATA[15:0]) & IMPL_MASK) && BVALID)
    else $error("pin write missed the latch");

  chk_unimpl_pad: assert property ( // R7
    PIN_OE_N[NPIN-1] && !PU_EN[NPIN-1] && !PD_EN[NPIN-1])
    else $error("unimplemented pin enabled");

  chk_rmp_null: assert property ( // R18 R19
    (q.rin[0] > RIN_MAX) |-> !RMP_IN[0])
    else $error("unmapped remap input not low");

  // bus takes each request once and answers hold until taken, as the master expects
  chk_wr_once: assert property (
    AWREADY |=> BVALID && !AWREADY)
    else $error("write taken twice");

  chk_rd_once: assert property (
    ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read taken twice");

  chk_bresp_hold: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");

  chk_rdata_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");

  cov_write: cover property (AWREADY ##1 BVALID && BREADY);
  cov_read: cover property (ARVALID && ARREADY ##1 RVALID);
  cov_change: cover property (cn_hit ##1 CN_REQ);
  cov_remap: cover property (q.rout[0] != 4'h0 && !PIN_OE_N[0]);
  cov_fixed: cover property (FIX_EN[2] && FIX_OE[2] && !PIN_OE_N[2]);

endmodule : gps_top

// *** verif/gps_pads.sv ***
// board side of the pads: one level per pin from every driver
// assumes the bench drives ext_en and ext_val for board parts
`timescale 1ns/1ns
module gps_pads
  import gps_pkg::*;
(
  input wire logic clk, // bench clock
  input wire logic [NPIN-1:0] dout, // design pad data
  input wire logic [NPIN-1:0] oe_n, // design enable, low drives
  input wire logic [NPIN-1:0] pu, // weak pull-up on
  input wire logic [NPIN-1:0] pd, // weak pull-down on
  input wire logic [NPIN-1:0] ext_en, // board part drives
  input wire logic [NPIN-1:0] ext_val, // board part level
  output logic [NPIN-1:0] lvl // level at the pad
);
  // ==========================================================
  // pad resolution
  logic [NPIN-1:0] flt_q = '0;
  // a floating pad wanders, so no test can lean on a stale level
  always_ff @(posedge clk) flt_q <= ~flt_q;
  // design drive first, then board parts, then the weak pulls
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (!oe_n[i]) lvl[i] = dout[i];
      else if (ext_en[i]) lvl[i] = ext_val[i];
      else if (pu[i]) lvl[i] = 1'b1;
      else if (pd[i]) lvl[i] = 1'b0;
      else lvl[i] = flt_q[i];
    end
  end
endmodule : gps_pads

// *** verif/test_gpio_port_with_pin_select.sv ***
// self-checking bench for the pin-select gpio port
// assumes gps_top and the gps_pads board model, one clock
`timescale 1ns/1ns
module test_gpio_port_with_pin_select;
  import gps_pkg::*;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, cn_req;
  logic [1:0] bresp, rresp, rmp_in, rs;
  logic [31:0] rdata, rv;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe_n, pu_en, pd_en, fix_in;
  logic [NPIN-1:0] ext_en = '0, ext_val = '0;
  logic [NPIN-1:0] fix_en = '0, fix_oe = '0, fix_out = '0;
  logic [NEXT-1:0] rp_ext = '0;
  logic [NPER-1:0] per_out = '0, per_oe = '0;
  int bad_count = 0;
  int checks = 0;

  // 50 mhz
  always #10 clk = ~clk;

  gps_top gps_top_inst (.CLK(clk), .RSTN(rstn), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PU_EN(pu_en),
    .PD_EN(pd_en), .RP_EXT(rp_ext), .FIX_EN(fix_en), .FIX_OE(fix_oe),
    .FIX_OUT(fix_out), .FIX_IN(fix_in), .PER_OUT(per_out),
    .PER_OE(per_oe), .RMP_IN(rmp_in), .CN_REQ(cn_req));

  gps_pads gps_pads_inst (.clk(clk), .dout(pin_out), .oe_n(pin_oe_n),
    .pu(pu_en), .pd(pd_en), .ext_en(ext_en), .ext_val(ext_val),
    .lvl(pin_in));

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // wait n edges, then look at settled levels mid-cycle
  task automatic wc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wc

  // address and data offered together, response held for
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge clk);
    while ((awready & wready) !== 1'b1) @(negedge clk);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge clk);
    while (bvalid !== 1'b1) @(negedge clk);
    rs = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge clk);
    while (arready !== 1'b1) @(negedge clk);
    @(posedge clk);
    arvalid <= 1'b0;
    @(negedge clk);
    while (rvalid !== 1'b1) @(negedge clk);
    rv = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    rd(a);
    chk(nm, rv, e);
  endtask : rc

  // ==========================================================
  // scenarios
  task automatic t_port;
    wc(0);
    chk("oe", 32'(pin_oe_n), 32'hffff);
    chk("rmp", 32'(rmp_in), 32'h0);
    rc("dir", A_DIR, 32'h7fff);
    chk("rresp", 32'(rs), 32'(RESP_OK));
    wr(A_LAT, 32'hffff);
    rc("lat", A_LAT, 32'h7fff);
    wr(A_PIN, 32'h1234);
    rc("lat", A_LAT, 32'h1234);
    wr(A_WPU, 32'h0);
    wr(A_DIR, 32'h0);
    wc(0);
    chk("oe", 32'(pin_oe_n), 32'h8000);
    chk("out", 32'(pin_out & 16'h7fff), 32'h1234);
    @(posedge clk);
    ext_en <= 16'h8000;
    ext_val <= 16'hffff;
    wc(4);
    rc("pin", A_PIN, 32'h1234);
    $display("port test done");
  endtask : t_port

  task automatic t_odc;
    wr(A_LAT, 32'h0f0f);
    // board resistors pull open-drain pins 0 to 3; weak pull-ups stay off
    ext_en <= 16'h800f;
    wr(A_ODC, 32'h00ff);
    wr(A_WPD, 32'h7f00);
    wc(0);
    chk("oe", 32'(pin_oe_n), 32'h800f);
    chk("pd", 32'(pd_en & 16'h7fff), 32'h7f00);
    wc(4);
    rc("pin", A_PIN, 32'h0f0f);
    wr(A_ODC, 32'h0);
    wr(A_WPU, 32'h0);
    wr(A_WPD, 32'h0);
    $display("open drain test done");
  endtask : t_odc

  task automatic t_ana;
    wr(A_DIR, 32'hffff);
    ext_en <= 16'hffff;
    ext_val <= 16'hffff;
    wr(A_WPU, 32'h00ff);
    wr(A_APC, 32'h000f);
    wc(4);
    chk("pu", 32'(pu_en), 32'h00ff);
    rc("pin", A_PIN, 32'h7ff0);
    per_oe <= 4'hf;
    per_out <= 4'hf;
    wr(A_RO0, 32'h1);
    wr(A_WPU, 32'h0);
    wr(A_DIR, 32'hfffd);
    wc(0);
    chk("oe", 32'(pin_oe_n[1:0]), 32'h1);
    chk("out", 32'(pin_out[1]), 32'h1);
    wr(A_APC, 32'h0);
    wc(0);
    chk("rmp", 32'({pin_oe_n[0], pin_out[0]}), 32'h1);
    wr(A_RO0, 32'h0);
    $display("analog test done");
  endtask : t_ana

  task automatic t_fix;
    ext_en <= 16'h0;
    per_out <= 4'h2;
    fix_en <= 16'h0004;
    fix_oe <= 16'h0004;
    wr(A_DIR, 32'h0);
    wr(A_LAT, 32'h0004);
    wc(4);
    chk("out", 32'(pin_out & ~pin_oe_n & 16'h7fff), 32'h0);
    rc("pin", A_PIN, 32'h0);
    wr(A_RO0, 32'h200);
    wc(0);
    chk("out", 32'({pin_oe_n[2], pin_out[2]}), 32'h1);
    wr(A_RO0, 32'h0);
    fix_oe <= 16'h0;
    wc(4);
    chk("out", 32'({pin_oe_n[2], pin_out[2]}), 32'h1);
    chk("fin", 32'(fix_in[2]), 32'h0);
    wr(A_DIR, 32'hffff);
    ext_en <= 16'h0004;
    ext_val <= 16'h0004;
    wc(4);
    chk("fin", 32'(fix_in[2]), 32'h1);
    $display("fixed peripheral test done");
  endtask : t_fix

  task automatic t_rmp;
    @(posedge clk);
    ext_en <= 16'h7fff;
    ext_val <= 16'h0020;
    rp_ext <= 30'h1000000;
    wr(A_RIN, 32'h0a05);
    wc(4);
    chk("rmp", 32'(rmp_in), 32'h3);
    @(posedge clk);
    rp_ext <= 30'h20000000;
    per_oe <= 4'hf;
    wr(A_RIN, 32'h0b6e);
    wc(4);
    chk("rmp", 32'(rmp_in), 32'h2);
    for (int k = 1; k <= 5; k++) begin
      @(posedge clk);
      per_out <= 4'(1 << (k - 1));
      wr(A_RO1, 32'(k));
      wc(0);
      chk("sel", 32'(pin_oe_n[8]), 32'(k > 4));
      if (k <= 4) chk("sel", 32'(pin_out[8]), 32'h1);
    end
    wr(A_RO1, 32'h0);
    $display("remap test done");
  endtask : t_rmp

  task automatic t_cn;
    ext_val <= 16'h0;
    wr(A_CNE, 32'h2);
    wc(4);
    wr(A_CNS, 32'h1);
    ext_val <= 16'h1;
    wc(5);
    chk("cn", 32'(cn_req), 32'h0);
    @(posedge clk);
    ext_val <= 16'h3;
    wc(5);
    chk("cn", 32'(cn_req), 32'h1);
    rc("cns", A_CNS, 32'h1);
    wr(A_CNS, 32'h1);
    wc(0);
    chk("cn", 32'(cn_req), 32'h0);
    $display("change notice test done");
  endtask : t_cn

  task automatic t_bad;
    rc("bad", 8'h30, 32'h0);
    chk("rresp", 32'(rs), 32'(RESP_ERR));
    wr(8'h30, 32'hffff);
    chk("bresp", 32'(rs), 32'(RESP_ERR));
    wr(8'h02, 32'h0);
    chk("bresp", 32'(rs), 32'(RESP_ERR));
    rc("dir", A_DIR, 32'h7fff);
    // a single byte strobe touches only the low byte
    wstrb <= 4'h1;
    wr(A_DIR, 32'h0);
    wstrb <= 4'hf;
    rc("dir", A_DIR, 32'h7f00);
    $display("unmapped test done");
  endtask : t_bad

  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_port();
    t_odc();
    t_ana();
    t_fix();
    t_rmp();
    t_cn();
    t_bad();
    results();
  end

  // the run takes a few hundred cycles; this is far past it
  initial begin
    #1000000;
    bad_count++;
    results();
  end
endmodule : test_gpio_port_with_pin_select
